// ===== hw/pcs_mgmt_defines.svh
// register offsets, field positions, reset values and timing counts for the management bank
`ifndef PCS_MGMT_DEFINES_SVH
`define PCS_MGMT_DEFINES_SVH

// ----------------------------------------
// register offsets (5-bit register address)
// ----------------------------------------
`define REG_PCS_CONTROL        5'h00
`define REG_PCS_STATUS         5'h01
`define REG_LOCAL_ADVERT       5'h04
`define REG_PARTNER_ABILITY    5'h05
`define REG_NEG_EXPANSION      5'h06
`define REG_EXTENDED_STATUS    5'h0f

// ----------------------------------------
// control field positions
// ----------------------------------------
`define CTL_RESET_BIT          15
`define CTL_LOOPBACK_BIT       14
`define CTL_SPEED_LSB_BIT      13
`define CTL_NEG_ENABLE_BIT     12
`define CTL_POWER_DOWN_BIT     11
`define CTL_ISOLATE_BIT        10
`define CTL_RESTART_NEG_BIT    9
`define CTL_DUPLEX_BIT         8
`define CTL_SPEED_MSB_BIT      6
`define CTL_UNIDIR_BIT         5

// ----------------------------------------
// status field positions and advert rate field
// ----------------------------------------
`define STS_EXT_STATUS_BIT     8
`define STS_UNIDIR_CAP_BIT     7
`define STS_NEG_COMPLETE_BIT   5
`define STS_NEG_ABILITY_BIT    3
`define STS_LINK_BIT           2
`define ADV_RATE_MSB           11
`define ADV_RATE_LSB           10

// ----------------------------------------
// rate codes and reset values
// ----------------------------------------
`define RATE_1G                2'h2
`define RATE_100M              2'h1
`define RATE_10M               2'h0
`define CONTROL_RESET          16'h1140
`define ADVERT_RESET_X         16'h0020
`define ADVERT_RESET_PHY       16'h0801
`define ADVERT_RESET_MAC       16'h4001

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS          50
`define PCS_RESET_TIME_NS      200
`define PCS_RESET_CYCLES       ((`PCS_RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== hw/pcs_mgmt_pkg.sv
// types shared by the management bank
package pcs_mgmt_pkg;

	typedef enum logic {
		proto_sgmii,
		proto_1000x
	} pcs_protocol_t;

	typedef struct packed {
		logic       pcs_reset;
		logic       loopback;
		logic       neg_enable;
		logic       power_down;
		logic       isolate;
		logic       neg_restart;
		logic       unidirectional;
		logic [1:0] rate;
	} pcs_ctrl_t;

	typedef struct packed {
		logic        link_up;
		logic        neg_complete;
		logic        unidir_cap;
		logic [15:0] partner_ability;
		logic [15:0] expansion;
		logic [15:0] extended_status;
	} pcs_core_status_t;

	typedef struct packed {
		logic        write;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} mgmt_req_t;

endpackage

// ===== hw/pcs_mgmt_rate_resolve.sv
// management register bank with rate resolution for the bridge pcs
//
// Function
// - drive 2-bit operating rate to adaptation
// - resolve rate from protocol, mode, negotiation
// - resolved rate steers tx/rx rate adaptation
// - mac/phy side from static pin
// - protocol switchable at run time
// - control, status, advert, partner, expansion, extended
// - parallel host access in easy build
// - map 0x0,0x1,0x4,0x5,0x6,0xf; rest read-only
// - control bit 15 self-clearing pcs reset
// - bits 13 and 6 form speed
// - speed stuck at 10 in 1000x
// - sgmii speed writable, used when negotiation off
// - negotiated sgmii rate from bits 11:10 of advert (phy side) or partner ability (mac side)
// - control bit 11 powers pcs down
// - control bit 9 self-clearing negotiation restart
// - link status latches low, clears on read
// - duplex bit writable, no effect
`timescale 1ns/1ps
`default_nettype none
`include "pcs_mgmt_defines.svh"

module pcs_mgmt_rate_resolve
	import pcs_mgmt_pkg::*;
#(
	parameter int RESET_CYCLES = `PCS_RESET_CYCLES
) (
	input  wire logic                           i_clk_sys,
	input  wire logic                           i_rst_b,
	input  wire logic                           i_sgmii_phy_side,
	input  wire logic                           i_pcs_protocol_select,
	input  wire pcs_mgmt_pkg::mgmt_req_t        i_req,
	input  wire logic                           i_req_valid,
	input  wire pcs_mgmt_pkg::pcs_core_status_t i_core_status,
	output logic [15:0]                         o_rdata,
	output logic                                o_rdata_valid,
	output pcs_mgmt_pkg::pcs_ctrl_t             o_ctrl
);
	import pcs_mgmt_pkg::*;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0]    side_sync;
	logic [1:0]    proto_sync;
	logic [1:0]    link_sync;
	wire logic     phy_side = side_sync[1];
	wire pcs_protocol_t protocol = proto_sync[1] ? proto_1000x : proto_sgmii;
	wire logic     link_now = link_sync[1];

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			side_sync  <= 2'h0;
			proto_sync <= 2'h0;
			link_sync  <= 2'h0;
		end else begin
			side_sync  <= {side_sync[0], i_sgmii_phy_side};
			proto_sync <= {proto_sync[0], i_pcs_protocol_select};
			link_sync  <= {link_sync[0], i_core_status.link_up};
		end
	end

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [15:0] control;
	logic [15:0] advert;
	logic        advert_written;
	logic        link_latched;
	logic [$clog2(RESET_CYCLES+1)-1:0] reset_count;

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	wire logic wr = i_req_valid & i_req.write;
	wire logic rd = i_req_valid & ~i_req.write;
	wire logic hit_control  = i_req.addr == `REG_PCS_CONTROL;
	wire logic hit_status   = i_req.addr == `REG_PCS_STATUS;
	wire logic hit_advert   = i_req.addr == `REG_LOCAL_ADVERT;
	wire logic hit_partner  = i_req.addr == `REG_PARTNER_ABILITY;
	wire logic hit_expand   = i_req.addr == `REG_NEG_EXPANSION;
	wire logic hit_extended = i_req.addr == `REG_EXTENDED_STATUS;
	wire logic wr_control   = wr & hit_control;
	wire logic wr_advert    = wr & hit_advert & ~(protocol == proto_sgmii & ~phy_side);
	wire logic rd_status    = rd & hit_status;

	// speed field: any value in sgmii, stuck at 10 in 1000x
	wire logic [1:0] speed_stored = {control[`CTL_SPEED_MSB_BIT], control[`CTL_SPEED_LSB_BIT]};
	wire logic [1:0] forced_rate = (protocol == proto_1000x) ? `RATE_1G : speed_stored;

	// advertised ability view per mode
	function automatic logic [15:0] advert_default(input pcs_protocol_t p, input logic phy);
		if (p == proto_1000x)
			return `ADVERT_RESET_X;
		else if (phy)
			return `ADVERT_RESET_PHY;
		else
			return `ADVERT_RESET_MAC;
	endfunction

	wire logic [15:0] advert_view = (protocol == proto_sgmii & ~phy_side) ? `ADVERT_RESET_MAC
		: (advert_written ? advert : advert_default(protocol, phy_side));
	wire logic [1:0] advertised_rate = advert_view[`ADV_RATE_MSB:`ADV_RATE_LSB];
	wire logic [1:0] partner_rate =
		i_core_status.partner_ability[`ADV_RATE_MSB:`ADV_RATE_LSB];

	// ----------------------------------------
	// rate resolution
	// ----------------------------------------
	wire logic neg_on = control[`CTL_NEG_ENABLE_BIT];
	wire logic [1:0] next_rate = (protocol == proto_1000x) ? `RATE_1G
		: (!neg_on ? forced_rate
		: (phy_side ? advertised_rate : partner_rate));

	// ----------------------------------------
	// status word
	// ----------------------------------------
	wire logic [15:0] status_word = (16'h0001 << `STS_EXT_STATUS_BIT)
		| (16'h0001 << `STS_NEG_ABILITY_BIT)
		| ({15'h0000, i_core_status.unidir_cap} << `STS_UNIDIR_CAP_BIT)
		| ({15'h0000, i_core_status.neg_complete} << `STS_NEG_COMPLETE_BIT)
		| ({15'h0000, link_latched} << `STS_LINK_BIT);

	// control readback: self-clearing bits read as live state, speed as forced rate (held value in sgmii, 10 in 1000x)
	wire logic [15:0] control_view = {control[15:14], forced_rate[0], control[12:7],
		forced_rate[1], control[5], 5'h00};

	wire logic [15:0] next_rdata = hit_control ? control_view
		: hit_status   ? status_word
		: hit_advert   ? advert_view
		: hit_partner  ? i_core_status.partner_ability
		: hit_expand   ? i_core_status.expansion
		: hit_extended ? i_core_status.extended_status
		: 16'h0000;

	// ----------------------------------------
	// control register
	// ----------------------------------------
	wire logic reset_done = control[`CTL_RESET_BIT] & (reset_count == '0);
	wire logic [15:0] wmask = 16'h7f60; // reset, restart handled separately; low bits stuck at 0
	wire logic [15:0] next_control_w = (control & ~wmask) | (i_req.wdata & wmask);

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			control <= `CONTROL_RESET;
		end else begin
			if (wr_control) begin
				control <= next_control_w;
				control[`CTL_RESET_BIT] <= i_req.wdata[`CTL_RESET_BIT] | control[`CTL_RESET_BIT];
				control[`CTL_RESTART_NEG_BIT] <= i_req.wdata[`CTL_RESTART_NEG_BIT];
			end else begin
				if (reset_done)
					control[`CTL_RESET_BIT] <= 1'b0;
				control[`CTL_RESTART_NEG_BIT] <= 1'b0;
			end
		end
	end

	// pcs reset hold counter
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			reset_count <= '0;
		end else if (wr_control & i_req.wdata[`CTL_RESET_BIT] & ~control[`CTL_RESET_BIT]) begin
			reset_count <= ($clog2(RESET_CYCLES+1))'(RESET_CYCLES - 1);
		end else if (reset_count != '0) begin
			reset_count <= reset_count - 1'b1;
		end
	end

	// ----------------------------------------
	// advertised ability register
	// ----------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			advert         <= 16'h0000;
			advert_written <= 1'b0;
		end else if (wr_advert) begin
			advert         <= i_req.wdata;
			advert_written <= 1'b1;
		end
	end

	// ----------------------------------------
	// latched link status
	// ----------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			link_latched <= 1'b0;
		end else if (!link_now) begin
			link_latched <= 1'b0;
		end else if (rd_status) begin
			link_latched <= 1'b1;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata       <= 16'h0000;
			o_rdata_valid <= 1'b0;
			o_ctrl        <= '0;
		end else begin
			o_rdata_valid <= rd;
			if (rd)
				o_rdata <= next_rdata;
			o_ctrl.pcs_reset      <= control[`CTL_RESET_BIT];
			o_ctrl.loopback       <= control[`CTL_LOOPBACK_BIT];
			o_ctrl.neg_enable     <= control[`CTL_NEG_ENABLE_BIT];
			o_ctrl.power_down     <= control[`CTL_POWER_DOWN_BIT];
			o_ctrl.isolate        <= control[`CTL_ISOLATE_BIT];
			o_ctrl.neg_restart    <= control[`CTL_RESTART_NEG_BIT];
			o_ctrl.unidirectional <= control[`CTL_UNIDIR_BIT];
			o_ctrl.rate           <= next_rate;
		end
	end

endmodule // pcs_mgmt_rate_resolve
`default_nettype wire

// ===== verification/pcs_mgmt_rate_resolve_assertions.sv
// concurrent checks on the management bank ports
`timescale 1ns/1ps
`default_nettype none
module pcs_mgmt_rate_resolve_assertions
	import pcs_mgmt_pkg::*;
#(
	parameter int RESET_CYCLES = 4
) (
	input wire logic                           i_clk_sys,
	input wire logic                           i_rst_b,
	input wire logic                           i_sgmii_phy_side,
	input wire logic                           i_pcs_protocol_select,
	input wire pcs_mgmt_pkg::mgmt_req_t        i_req,
	input wire logic                           i_req_valid,
	input wire pcs_mgmt_pkg::pcs_core_status_t i_core_status,
	input wire logic [15:0]                    o_rdata,
	input wire logic                           o_rdata_valid,
	input wire pcs_mgmt_pkg::pcs_ctrl_t        o_ctrl
);
	// ----------------------------------------
	// helpers and checks
	// ----------------------------------------
	int        rst_len;
	wire logic rd     = i_req_valid && !i_req.write;
	wire logic wr_ctl = i_req_valid && i_req.write && i_req.addr == 5'h00 && !i_req.wdata[15];
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		rst_len <= !i_rst_b ? 0 : (o_ctrl.pcs_reset ? rst_len + 1 : 0);
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	a_read_answer: assert property (rd |=> o_rdata_valid)
		else $error("read not answered");
	a_no_stray_valid: assert property (!rd |=> !o_rdata_valid)
		else $error("answer without read");
	a_rate_1000x: assert property (i_pcs_protocol_select [*5] |-> o_ctrl.rate == 2'h2)
		else $error("rate not 1g in 1000x");
	a_speed_1000x: assert property (i_pcs_protocol_select [*5] ##0 (rd && i_req.addr == 5'h00)
		|=> o_rdata[6] && !o_rdata[13])
		else $error("speed field not 10 in 1000x");
	a_reset_length: assert property ($fell(o_ctrl.pcs_reset) |-> rst_len == RESET_CYCLES)
		else $error("pcs reset length wrong");
	a_ctl_write: assert property (wr_ctl |-> ##2 {o_ctrl.loopback, o_ctrl.neg_enable, o_ctrl.power_down,
		o_ctrl.isolate} == $past({i_req.wdata[14], i_req.wdata[12:10]}, 2))
		else $error("control bits not applied");
	a_restart_pulse: assert property (wr_ctl && i_req.wdata[9] |-> ##2 o_ctrl.neg_restart ##1 !o_ctrl.neg_restart)
		else $error("restart not one pulse");
	a_unmapped_zero: assert property (rd && !(i_req.addr inside {5'h00, 5'h01, 5'h04, 5'h05, 5'h06, 5'h0f})
		|=> o_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_ctl_stuck: assert property (rd && i_req.addr == 5'h00 |=> o_rdata[4:0] == 5'h00 && !o_rdata[7])
		else $error("stuck control bits set");
	a_status_fixed: assert property (rd && i_req.addr == 5'h01 |=> o_rdata[8] && o_rdata[3])
		else $error("fixed status bits clear");
endmodule // pcs_mgmt_rate_resolve_assertions

bind pcs_mgmt_rate_resolve pcs_mgmt_rate_resolve_assertions #(.RESET_CYCLES(RESET_CYCLES)) i_chk (
	.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_sgmii_phy_side(i_sgmii_phy_side),
	.i_pcs_protocol_select(i_pcs_protocol_select), .i_req(i_req), .i_req_valid(i_req_valid),
	.i_core_status(i_core_status), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid), .o_ctrl(o_ctrl));
`default_nettype wire

// ===== verification/mgmt_station_model.sv
// management station model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module mgmt_station_model
	import pcs_mgmt_pkg::*;
(
	input  wire logic               i_clk_sys,
	input  wire logic [15:0]        i_rdata,
	input  wire logic               i_rdata_valid,
	output pcs_mgmt_pkg::mgmt_req_t o_req,
	output logic                    o_req_valid
);
	// ----------------------------------------
	// one access, answer taken in the next cycle, at its negedge
	// ----------------------------------------
	initial begin
		o_req = '0;
		o_req_valid = 1'b0;
	end
	task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
		@(posedge i_clk_sys);
		o_req <= '{write: w, addr: a, wdata: d};
		o_req_valid <= 1'b1;
		@(posedge i_clk_sys);
		o_req_valid <= 1'b0;
		o_req <= '{write: 1'b0, addr: ~a, wdata: ~d};
		@(negedge i_clk_sys);
		q = i_rdata_valid ? i_rdata : 16'hdead;
	endtask
endmodule // mgmt_station_model
`default_nettype wire

// ===== verification/pcs_mgmt_rate_resolve_tb.sv
// self-checking bench for the management bank
`timescale 1ns/1ps
`default_nettype none
module pcs_mgmt_rate_resolve_tb;
	import pcs_mgmt_pkg::*;
	logic             clk_sys = 1'b0;
	logic             rst_b = 1'b0;
	logic             phy_side = 1'b0;
	logic             proto = 1'b0;
	pcs_core_status_t core = '{link_up: 1'b1, neg_complete: 1'b1, unidir_cap: 1'b0,
		partner_ability: 16'h0400, expansion: 16'h0002, extended_status: 16'h8000};
	mgmt_req_t        req;
	logic             req_valid;
	logic [15:0]      rdata;
	logic             rdata_valid;
	pcs_ctrl_t        ctrl;
	logic [15:0]      q;
	int               fails = 0;
	int               compares = 0;
	always #25 clk_sys = ~clk_sys;
	pcs_mgmt_rate_resolve i_dut (.i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_sgmii_phy_side(phy_side),
		.i_pcs_protocol_select(proto), .i_req(req), .i_req_valid(req_valid), .i_core_status(core),
		.o_rdata(rdata), .o_rdata_valid(rdata_valid), .o_ctrl(ctrl));
	mgmt_station_model station (.i_clk_sys(clk_sys), .i_rdata(rdata), .i_rdata_valid(rdata_valid),
		.o_req(req), .o_req_valid(req_valid));
	// ----------------------------------------
	// compare and scenarios
	// ----------------------------------------
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic rate_is(input logic [1:0] exp);
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("rate", {14'h0, exp}, {14'h0, ctrl.rate});
	endtask
	task automatic t_map;
		logic [4:0]  a[4] = '{5'h05, 5'h06, 5'h0f, 5'h02};
		logic [15:0] e[4] = '{16'h0400, 16'h0002, 16'h8000, 16'h0000};
		station.access(1'b0, 5'h00, 16'h0, q);
		chk("control", 16'h1140, q);
		station.access(1'b1, 5'h04, 16'h0800, q);
		station.access(1'b0, 5'h04, 16'h0, q);
		chk("advert", 16'h4001, q);
		for (int i = 0; i < 4; i++) begin
			station.access(1'b1, a[i], 16'hffff, q);
			station.access(1'b0, a[i], 16'h0, q);
			chk("read only", e[i], q);
		end
	endtask
	task automatic t_mac;
		logic [15:0] d[3] = '{16'h0000, 16'h2000, 16'h0140};
		logic [1:0]  r[3] = '{2'h0, 2'h1, 2'h2};
		rate_is(2'h1);
		for (int i = 0; i < 3; i++) begin
			station.access(1'b1, 5'h00, d[i], q);
			rate_is(r[i]);
			station.access(1'b0, 5'h00, 16'h0, q);
			chk("control", d[i], q);
		end
		station.access(1'b1, 5'h00, 16'h1000, q);
		rate_is(2'h1);
	endtask
	task automatic t_phy;
		@(posedge clk_sys);
		phy_side <= 1'b1;
		rate_is(2'h2);
		station.access(1'b1, 5'h04, 16'h0001, q);
		rate_is(2'h0);
		@(posedge clk_sys);
		phy_side <= 1'b0;
		rate_is(2'h1);
	endtask
	task automatic t_1000x;
		@(posedge clk_sys);
		proto <= 1'b1;
		rate_is(2'h2);
		station.access(1'b1, 5'h00, 16'h0000, q);
		rate_is(2'h2);
		station.access(1'b0, 5'h00, 16'h0, q);
		chk("control", 16'h0040, q);
		@(posedge clk_sys);
		proto <= 1'b0;
		rate_is(2'h0);
	endtask
	task automatic t_self_clear;
		station.access(1'b1, 5'h00, 16'h8000, q);
		repeat (8) @(posedge clk_sys);
		station.access(1'b0, 5'h00, 16'h0, q);
		chk("reset bit", 16'h0, q & 16'h8000);
		station.access(1'b1, 5'h00, 16'h1200, q);
		station.access(1'b0, 5'h00, 16'h0, q);
		chk("restart bit", 16'h1000, q & 16'h1200);
		station.access(1'b1, 5'h00, 16'h5c20, q);
		@(negedge clk_sys);
		chk("ctrl", 16'h00f5, {7'h00, ctrl});
		station.access(1'b0, 5'h00, 16'h0, q);
		chk("control", 16'h5c20, q);
	endtask
	task automatic t_link;
		station.access(1'b0, 5'h01, 16'h0, q);
		@(posedge clk_sys);
		core.link_up <= 1'b0;
		repeat (4) @(posedge clk_sys);
		core.link_up <= 1'b1;
		repeat (4) @(posedge clk_sys);
		station.access(1'b0, 5'h01, 16'h0, q);
		chk("link latched", 16'h0, q & 16'h0004);
		station.access(1'b0, 5'h01, 16'h0, q);
		chk("link live", 16'h0004, q & 16'h0004);
	endtask
	task automatic complete_run;
		$display("fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk_sys);
		fails++;
		complete_run();
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_map();
		t_mac();
		t_phy();
		t_1000x();
		t_self_clear();
		t_link();
		complete_run();
	end
endmodule // pcs_mgmt_rate_resolve_tb
`default_nettype wire
